// *** inc/vca_map.vh ***
// register map and field constants of the channel arbitration register bank
`ifndef VCA_MAP_VH
`define VCA_MAP_VH

`define VCA_OFS_CAP_TWO 12'h148
`define VCA_OFS_CTRL_STAT 12'h14C
`define VCA_OFS_RES_CAP_ZERO 12'h150

`define VCA_ARB_CAP_ON 8'h03
`define VCA_ARB_CAP_OFF 8'h00
`define VCA_TBL_OFS_ON 8'h03
`define VCA_TBL_OFS_OFF 8'h00
`define VCA_PORT_ARB_CAP 8'h19
`define VCA_PORT_TBL_OFS 8'h04
`define VCA_MAX_SLOTS_RST 7'h7F
`define VCA_SEL_RST 3'h0
`define VCA_SEL_MAX_VALID 3'h1

`define VCA_LOAD_BIT 0
`define VCA_SEL_LSB 1
`define VCA_SEL_MSB 3
`define VCA_STAT_BIT 16
`define VCA_SLOTS_LSB 16
`define VCA_SLOTS_MSB 22
`define VCA_HI_LSB 24
`define VCA_HI_MSB 31

`define VCA_LOAD_CYCLES 4'h4

`endif

// *** src/vca_regs.v ***
// channel arbitration capability, control and status register bank
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "vca_map.vh"

// Operation
// - arbitration capability advertises round robin and 32-phase weighted.
// - capability and table offset reset to 03h if strap bit set, else 00h.
// - bits 31:24 of capability two give channel table offset in 16-byte units.
// - writing one to load bit adopts table; bit always reads zero.
// - select keeps only 0 or 1; other writes give default; resets 000b.
// - table status sets on table entry write, clears when load finishes.
// - port arbitration capability of channel zero resets to 19h.
// - advanced packet switching bit 14 reads zero.
// - snoop rejection bit 15 reads zero.
// - maximum time slots field resets 7Fh, may be replaced by autoload.
// - port table zero offset reads 04h in 16-byte units.
// - strap bit is sampled from second channel strap pin at reset release.
module vca_regs #(
    parameter LOAD_CYCLES = 4 // cycles hardware takes to adopt a table
) (
    input wire mclk, // 10 MHz clock
    input wire resetn, // asynchronous reset, active low
    input wire clk_en, // freezes all state while low
    input wire [11:0] avs_address, // byte address
    input wire avs_read, // read request
    input wire avs_write, // write request
    input wire [31:0] avs_writedata, // write data
    input wire [3:0] avs_byteenable, // byte lanes
    output reg [31:0] avs_readdata, // read data
    output reg avs_waitrequest, // high until answer
    input wire second_channel_strap, // strap pin, asynchronous
    input wire table_entry_write, // pulse: software wrote a table entry
    input wire slots_load_valid, // pulse: autoload value present
    input wire [6:0] slots_load_value, // autoloaded maximum time slots
    output reg table_load_busy, // hardware adopting the table
    output reg [2:0] arb_select, // active arbitration scheme
    output reg strap_bit // sampled extended channel count bit 0
);

    reg strap_meta_q;
    reg strap_sync_q;
    reg strap_taken_q;
    reg [1:0] strap_age_q;
    reg sel_q;
    reg stat_q;
    reg [3:0] load_cnt_q;
    reg [6:0] slots_q;
    reg ack_q;
    reg [31:0] rdata_d;
    wire hit;
    wire wr_go;
    wire load_req;
    wire load_done;

    function [31:0] cap_two_word;
        input s;
        begin
            cap_two_word = 32'h0000_0000;
            cap_two_word[7:0] =
                s ? `VCA_ARB_CAP_ON : `VCA_ARB_CAP_OFF;
            cap_two_word[`VCA_HI_MSB:`VCA_HI_LSB] =
                s ? `VCA_TBL_OFS_ON : `VCA_TBL_OFS_OFF;
        end
    endfunction

    assign hit = (avs_address == `VCA_OFS_CAP_TWO) ||
                 (avs_address == `VCA_OFS_CTRL_STAT) ||
                 (avs_address == `VCA_OFS_RES_CAP_ZERO);
    // a request is answered one cycle after it is seen
    assign wr_go = avs_write && !ack_q &&
                   (avs_address == `VCA_OFS_CTRL_STAT) && avs_byteenable[0];
    assign load_req = wr_go && avs_writedata[`VCA_LOAD_BIT];
    assign load_done = (load_cnt_q == 4'h1);

    // strap passes two flops; first flop read by the second only
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            strap_meta_q <= 1'b0;
            strap_sync_q <= 1'b0;
            strap_taken_q <= 1'b0;
            strap_age_q <= 2'h0;
            strap_bit <= 1'b0;
        end else if (clk_en) begin
            strap_meta_q <= second_channel_strap;
            strap_sync_q <= strap_meta_q;
            // wait until the pin has crossed both flops before capturing
            if (strap_age_q != 2'h2)
                strap_age_q <= strap_age_q + 2'h1;
            else if (!strap_taken_q) begin
                strap_taken_q <= 1'b1;
                strap_bit <= strap_sync_q;
            end
        end
    end

    always @* begin
        rdata_d = 32'h0000_0000;
        case (avs_address)
            `VCA_OFS_CAP_TWO: rdata_d = cap_two_word(strap_bit);
            `VCA_OFS_CTRL_STAT: begin
                rdata_d[`VCA_SEL_MSB:`VCA_SEL_LSB] = {2'b00, sel_q};
                rdata_d[`VCA_STAT_BIT] = stat_q;
                // load bit stays zero on read
            end
            `VCA_OFS_RES_CAP_ZERO: begin
                rdata_d[7:0] = `VCA_PORT_ARB_CAP;
                // bits 14 and 15 left zero
                rdata_d[`VCA_SLOTS_MSB:`VCA_SLOTS_LSB] = slots_q;
                rdata_d[`VCA_HI_MSB:`VCA_HI_LSB] = `VCA_PORT_TBL_OFS;
            end
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ack_q <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            sel_q <= 1'b0;
            stat_q <= 1'b0;
            load_cnt_q <= 4'h0;
            slots_q <= `VCA_MAX_SLOTS_RST;
            table_load_busy <= 1'b0;
            arb_select <= `VCA_SEL_RST;
        end else if (clk_en) begin
            ack_q <= (avs_read || avs_write) && !ack_q;
            avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
            if (avs_read && !ack_q)
                avs_readdata <= hit ? rdata_d : 32'h0000_0000;
            if (wr_go) begin
                // values other than 0 or 1 fall back to default
                sel_q <= (avs_writedata[`VCA_SEL_MSB:`VCA_SEL_LSB] ==
                          `VCA_SEL_MAX_VALID);
            end
            if (load_req && load_cnt_q == 4'h0)
                load_cnt_q <= LOAD_CYCLES[3:0];
            else if (load_cnt_q != 4'h0)
                load_cnt_q <= load_cnt_q - 4'h1;
            table_load_busy <= (load_cnt_q > 4'h1) ||
                               (load_req && load_cnt_q == 4'h0);
            // set wins over clear
            if (table_entry_write)
                stat_q <= 1'b1;
            else if (load_done)
                stat_q <= 1'b0;
            if (load_done || (load_req && LOAD_CYCLES == 0))
                arb_select <= {2'b00, sel_q};
            if (slots_load_valid)
                slots_q <= slots_load_value;
        end
    end

endmodule // vca_regs

// *** verification/vca_regs_asserts.sv ***
// port checker of the channel arbitration register bank
`timescale 1ns/10ps
module vca_regs_chk (
    input wire mclk, input wire resetn, input wire avs_read,
    input wire [11:0] avs_address, input wire [31:0] avs_readdata,
    input wire avs_waitrequest, input wire table_load_busy,
    input wire [2:0] arb_select, input wire strap_bit
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    wire rd = avs_read && !avs_waitrequest;
    wire [11:0] a = avs_address;
    wire [31:0] q = avs_readdata;
    wire [7:0] on = strap_bit ? 8'h03 : 8'h00;
    a_cap_two: assert property (rd && a == 12'h148
        |-> q == {on, 16'h0000, on}) else $error("bad cap two");
    a_res_cap: assert property (rd && a == 12'h150
        |-> q[15:0] == 16'h0019 && q[31:23] == 9'h008) else $error("bad cap");
    a_load_zero: assert property (rd && a == 12'h14C
        |-> !q[0] && q[15:4] == 12'h000 && q[31:17] == 15'h0000)
        else $error("bad ctrl");
    a_sel_field: assert property (rd && a == 12'h14C |-> q[3:2] == 2'h0)
        else $error("bad sel read");
    a_unmapped_zero: assert property (rd && a != 12'h148 && a != 12'h14C
        && a != 12'h150 |-> q == 32'h00000000) else $error("bad unmapped");
    a_sel_range: assert property (arb_select <= 3'h1)
        else $error("bad select");
    a_sel_moves: assert property ($changed(arb_select)
        |-> $fell(table_load_busy)) else $error("select moved");
    a_busy_ends: assert property ($rose(table_load_busy)
        |-> ##[1:16] !table_load_busy) else $error("load hangs");
    cover property (rd && a == 12'h14C && q[16]);
    cover property ($fell(table_load_busy));
    cover property ($rose(arb_select[0]));
endmodule // vca_regs_chk
bind vca_regs vca_regs_chk u_chk (.*);

// *** verification/test_virtual_channel_arbitration_regs.sv ***
// self-checking bench of the channel arbitration register bank
`timescale 1ns/10ps
module test_virtual_channel_arbitration_regs;
    logic mclk = 0, resetn = 0, avs_read = 0, avs_write = 0, tew = 0;
    logic strap = 0, slv = 0, avs_waitrequest, table_load_busy, strap_bit;
    logic [11:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata;
    logic [6:0] slots = 0;
    logic [2:0] arb_select;
    int miscompares = 0, n_tests = 0;
    vca_regs dut (.mclk(mclk), .resetn(resetn), .clk_en(1'b1),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .second_channel_strap(strap),
        .table_entry_write(tew), .slots_load_valid(slv),
        .slots_load_value(slots), .table_load_busy(table_load_busy),
        .arb_select(arb_select), .strap_bit(strap_bit));
    always #50 mclk = ~mclk;
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %0t %h %h", $time, s, e);
        end
    endtask
    // request held until waitrequest is seen low at a rising edge
    task bus(input logic w, input logic [11:0] ad, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge mclk);
        {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, ad, d};
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        {avs_write, avs_read} <= 2'b00;
    endtask
    task rst(input logic s);
        @(posedge mclk);
        {resetn, strap} <= {1'b0, s};
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask
    task ld;
        repeat (2) @(posedge mclk);
        while (table_load_busy !== 1'b0) @(posedge mclk);
    endtask
    task t_caps;
        logic [31:0] q;
        rst(1'b1);
        bus(1'b1, 12'h148, 32'hFFFFFFFF, q);
        bus(1'b0, 12'h148, 32'h0, q);
        chk(q, 32'h03000003);
        bus(1'b0, 12'h150, 32'h0, q);
        chk(q, 32'h047F0019);
        {slv, slots} <= {1'b1, 7'h2A};
        @(posedge mclk);
        slv <= 1'b0;
        bus(1'b0, 12'h150, 32'h0, q);
        chk(q, 32'h042A0019);
        bus(1'b0, 12'h154, 32'h0, q);
        chk(q, 32'h00000000);
        rst(1'b0);
        bus(1'b0, 12'h148, 32'h0, q);
        chk(q, 32'h00000000);
        $display("test caps done");
    endtask
    task t_ctrl;
        logic [31:0] q;
        tew <= 1'b1;
        @(posedge mclk);
        tew <= 1'b0;
        bus(1'b0, 12'h14C, 32'h0, q);
        chk(q, 32'h00010000);
        bus(1'b1, 12'h14C, 32'hFFFFFFF3, q);
        ld;
        chk({29'h0, arb_select}, 32'h1);
        bus(1'b0, 12'h14C, 32'h0, q);
        chk(q, 32'h00000002);
        bus(1'b1, 12'h14C, 32'h0000000B, q);
        ld;
        chk({29'h0, arb_select}, 32'h0);
        bus(1'b0, 12'h14C, 32'h0, q);
        chk(q, 32'h00000000);
        $display("test ctrl done");
    endtask
    task conclude;
        $display("checks %0d bad %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        t_caps;
        t_ctrl;
        conclude;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        miscompares++;
        conclude;
    end
endmodule // test_virtual_channel_arbitration_regs
